// ---- include/wdt_consts.vh ----
// Constants of the watchdog block: clock rates, register offsets,
// field positions, reset values and encodings.
// Assumes inclusion by bare name from the design files.
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// Timing
`define WDT_CLK_HZ        20000000
`define WDT_OSC_HZ        31000
`define WDT_OSC_DIV       (`WDT_CLK_HZ / `WDT_OSC_HZ)
`define WDT_PRE_LO_MAX    7'h1f
`define WDT_PRE_HI_MAX    7'h7f
`define WDT_PRE_LO_SHIFT  5'd5
`define WDT_PRE_HI_SHIFT  5'd7

// Register offsets
`define WDT_OFF_CONFIG    8'h00
`define WDT_OFF_RSTCTL    8'h04
`define WDT_OFF_STATUS    8'h08
`define WDT_OFF_CLEAR     8'h0c
`define WDT_OFF_ENABLE    8'h10
`define WDT_OFF_COUNT     8'h14

// Configuration word fields
`define WDT_CFG_PS_LSB    0
`define WDT_CFG_PSA_BIT   4
`define WDT_CFG_WIN_BIT   6
`define WDT_CFG_EN_LSB    8
`define WDT_CFG_PS_RST    4'hf
`define WDT_CFG_PSA_RST   1'b1
`define WDT_CFG_WIN_RST   1'b1
`define WDT_CFG_EN_RST    2'h0

// Reset control register fields
`define WDT_RC_IDLE_BIT   2
`define WDT_RC_SLEEP_BIT  3
`define WDT_RC_TMO_BIT    4
`define WDT_RC_SWEN_BIT   5

// Interrupt status, clear and enable layout
`define WDT_IRQ_W         3
`define WDT_IRQ_TMO       0
`define WDT_IRQ_WIN       1
`define WDT_IRQ_WAKE      2
`define WDT_ST_MODE_LSB   8

// Enable field encodings
`define WDT_EN_OFF        2'h0
`define WDT_EN_RUNIDLE    2'h1
`define WDT_EN_SOFT       2'h2
`define WDT_EN_ALWAYS     2'h3

// Bus responses
`define WDT_RESP_OKAY     2'h0
`define WDT_RESP_SLVERR   2'h2

`endif

// ---- hdl/wdt_count.v ----
// Prescaler and postscaler of the watchdog, with window detection.
// Assumes one tick pulse per oscillator period and a clear from the top.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"

module wdt_count (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        tick,
   input  wire        clear,
   input  wire        prescale_select_bit,
   input  wire [3:0]  postscale_select_field,
   output wire        timeout,
   output wire        in_window,
   output wire [21:0] elapsed
);
   reg  [6:0]  pre_cnt;
   reg  [14:0] post_cnt;
   wire [6:0]  pre_max;
   wire [15:0] post_n;
   wire [14:0] post_max;
   wire        pre_end;
   wire        post_end;
   wire [4:0]  shift;
   wire [22:0] period;

   // Nominal 1 ms or 4 ms at 31 kHz
   assign pre_max  = prescale_select_bit ? `WDT_PRE_HI_MAX : `WDT_PRE_LO_MAX;
   assign post_n   = 16'h0001 << postscale_select_field;
   assign post_max = post_n[14:0] - 15'h0001;
   assign pre_end  = (pre_cnt == pre_max);
   assign post_end = (post_cnt == post_max);
   assign timeout  = tick & pre_end & post_end;

   always @(posedge aclk) begin
      if (!aresetn || clear) begin
         pre_cnt  <= 7'h00;
         post_cnt <= 15'h0000;
      end else if (tick) begin
         if (pre_end) begin
            pre_cnt  <= 7'h00;
            post_cnt <= post_end ? 15'h0000 : post_cnt + 15'h0001;
         end else begin
            pre_cnt <= pre_cnt + 7'h01;
         end
      end
   end

   assign elapsed = prescale_select_bit ? {post_cnt, pre_cnt}
                                        : {2'b00, post_cnt, pre_cnt[4:0]};
   assign shift   = {1'b0, postscale_select_field} +
                    (prescale_select_bit ? `WDT_PRE_HI_SHIFT : `WDT_PRE_LO_SHIFT);
   assign period  = 23'h000001 << shift;
   assign in_window = ({1'b0, elapsed} >= (period - (period >> 2)));
endmodule

`default_nettype wire

// ---- hdl/wdt_top.v ----
// Watchdog timer with an AXI4-Lite register slave.
// Assumes core strobes are one-cycle pulses on aclk; device_reset is the
// synchronous device reset, aresetn the power-on reset of everything.
//
// Behaviour
// - Count on the low-power RC tick; turn the oscillator on while enabled.
// - Prescaler divides by 32 or 128, chosen by one configuration bit.
// - At 31 kHz the prescaler alone gives 1 ms or 4 ms.
// - Postscaler adds sixteen ratios from 1:1 to 1:32768.
// - Device reset and clock-switch completion clear all watchdog counters.
// - Entering or leaving sleep or idle clears all watchdog counters.
// - Clear instruction in normal run while enabled clears all watchdog counters.
// - Always-on mode counts in sleep and idle; timeout there wakes the core.
// - Timeout flag stays set until software or a power-save instruction clears it.
// - Windowed mode accepts a clear only in the last quarter.
// - Windowed mode: an early clear resets the device like a timeout.
// - Window disable bit at zero selects windowed mode.
// - Enable field 11 keeps the watchdog on regardless of software.
// - Enable field 10 runs the watchdog only while software enables it.
// - Every device reset clears the software enable bit.
// - Enable field 01 runs in run and idle, stops in sleep.
// - Power-save instruction clears the timeout flag and sets the sleep or idle flag.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"

module wdt_top #(
   parameter ADDR_W   = 8,
   parameter OSC_DIV  = `WDT_OSC_DIV
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] awaddr,
   input  wire              awvalid,
   output reg               awready,
   input  wire [31:0]       wdata,
   input  wire [3:0]        wstrb,
   input  wire              wvalid,
   output reg               wready,
   output reg  [1:0]        bresp,
   output reg               bvalid,
   input  wire              bready,
   input  wire [ADDR_W-1:0] araddr,
   input  wire              arvalid,
   output reg               arready,
   output reg  [31:0]       rdata,
   output reg  [1:0]        rresp,
   output reg               rvalid,
   input  wire              rready,
   input  wire              device_reset,
   input  wire              clock_switch_done,
   input  wire              watchdog_clear_instruction,
   input  wire              power_save_instruction,
   input  wire              power_save_idle,
   input  wire              power_save_exit,
   output reg               low_power_rc_osc_en,
   output reg               watchdog_reset_req,
   output reg               wake_req,
   output reg               irq
);
   localparam MODE_RUN   = 2'b00;
   localparam MODE_SLEEP = 2'b01;
   localparam MODE_IDLE  = 2'b10;
   localparam integer DIV_M1   = OSC_DIV - 1;
   localparam [15:0]  DIV_LAST = DIV_M1[15:0];

   // Configuration word
   reg  [3:0]  postscale_select_field;
   reg         prescale_select_bit;
   reg         window_disable_bit;
   reg  [1:0]  watchdog_enable_field;
   // Reset control register
   reg         software_watchdog_enable;
   reg         watchdog_timeout_flag;
   reg         sleep_flag;
   reg         idle_flag;
   // Interrupt block
   reg  [2:0]  irq_status;
   reg  [2:0]  irq_enable;
   // Core power state and oscillator tick
   reg  [1:0]  mode;
   reg  [1:0]  next_mode;
   reg  [15:0] tick_cnt;
   reg         tick;
   reg         run_en;
   // Bus state
   reg              aw_got;
   reg              w_got;
   reg [ADDR_W-1:0] wr_addr;
   reg [31:0]       wr_data;
   reg [3:0]        wr_strb;
   reg              sel_cfg;
   reg              sel_rstctl;
   reg              sel_clr;
   reg              sel_ena;
   reg              wr_hit;
   reg [31:0]       rd_word;
   reg              rd_hit;

   wire        cnt_timeout;
   wire        in_window;
   wire [21:0] elapsed;
   wire        do_write;
   wire [31:0] cfg_word;
   wire [31:0] rstctl_word;
   wire [31:0] cfg_new;
   wire [31:0] rstctl_new;
   wire        clr_ins;
   wire        early_clr;
   wire        clr_ok;
   wire        reset_evt;
   wire        wake_evt;
   wire        enter_ps;
   wire        leave_ps;
   wire        cnt_clear;
   wire [2:0]  irq_events;
   wire [2:0]  next_irq_status;

   // Byte-lane merge of a write into an old register value
   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] din;
      input [3:0]  strb;
      integer      i;
      begin
         wmerge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               wmerge[8*i +: 8] = din[8*i +: 8];
            end
         end
      end
   endfunction

   assign cfg_word = {22'h000000, watchdog_enable_field, 1'b0,
                      window_disable_bit, 1'b0, prescale_select_bit,
                      postscale_select_field};
   assign rstctl_word = {26'h0000000, software_watchdog_enable,
                         watchdog_timeout_flag, sleep_flag, idle_flag, 2'b00};
   assign cfg_new     = wmerge(cfg_word, wr_data, wr_strb);
   assign rstctl_new  = wmerge(rstctl_word, wr_data, wr_strb);

   // Enable decode
   always @* begin
      case (watchdog_enable_field)
         `WDT_EN_ALWAYS:  run_en = 1'b1;
         `WDT_EN_SOFT:    run_en = software_watchdog_enable;
         `WDT_EN_RUNIDLE: run_en = (mode != MODE_SLEEP);
         default:         run_en = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn || !run_en || cnt_clear) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b0;
      end else if (tick_cnt == DIV_LAST) begin
         tick_cnt <= 16'h0000;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 16'h0001;
         tick     <= 1'b0;
      end
   end

   wdt_count u_count (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .tick                   (tick),
      .clear                  (cnt_clear),
      .prescale_select_bit    (prescale_select_bit),
      .postscale_select_field (postscale_select_field),
      .timeout                (cnt_timeout),
      .in_window              (in_window),
      .elapsed                (elapsed)
   );

   // Clear instruction counts only in normal run while enabled
   assign clr_ins   = watchdog_clear_instruction & (mode == MODE_RUN) & run_en;
   assign early_clr = clr_ins & ~window_disable_bit & ~in_window;
   assign clr_ok    = clr_ins & ~early_clr;
   assign reset_evt = (cnt_timeout & (mode == MODE_RUN)) | early_clr;
   assign wake_evt  = cnt_timeout & (mode != MODE_RUN);
   assign enter_ps  = power_save_instruction & (mode == MODE_RUN);
   assign leave_ps  = (power_save_exit | wake_evt) & (mode != MODE_RUN);
   assign cnt_clear = device_reset | clock_switch_done | enter_ps | leave_ps |
                      clr_ok | reset_evt;

   // Core power state
   always @* begin
      next_mode = mode;
      case (mode)
         MODE_RUN: begin
            if (enter_ps) begin
               next_mode = power_save_idle ? MODE_IDLE : MODE_SLEEP;
            end
         end
         MODE_SLEEP,
         MODE_IDLE: begin
            if (leave_ps) begin
               next_mode = MODE_RUN;
            end
         end
         default: next_mode = MODE_RUN;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn || device_reset) begin
         mode <= MODE_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // Address decode of the latched write
   always @* begin
      sel_cfg  = 1'b0;
      sel_rstctl = 1'b0;
      sel_clr  = 1'b0;
      sel_ena  = 1'b0;
      wr_hit   = 1'b1;
      if (wr_addr == `WDT_OFF_CONFIG) begin
         sel_cfg = 1'b1;
      end else if (wr_addr == `WDT_OFF_RSTCTL) begin
         sel_rstctl = 1'b1;
      end else if (wr_addr == `WDT_OFF_CLEAR) begin
         sel_clr = 1'b1;
      end else if (wr_addr == `WDT_OFF_ENABLE) begin
         sel_ena = 1'b1;
      end else if (wr_addr == `WDT_OFF_STATUS || wr_addr == `WDT_OFF_COUNT) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;
      end
   end

   assign do_write = aw_got & w_got & ~bvalid;

   // Write channels: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         wr_addr <= {ADDR_W{1'b0}};
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `WDT_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wready  <= 1'b0;
            w_got   <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // Configuration word; kept across device reset like fuses
   always @(posedge aclk) begin
      if (!aresetn) begin
         postscale_select_field <= `WDT_CFG_PS_RST;
         prescale_select_bit    <= `WDT_CFG_PSA_RST;
         window_disable_bit     <= `WDT_CFG_WIN_RST;
         watchdog_enable_field  <= `WDT_CFG_EN_RST;
      end else if (do_write && sel_cfg) begin
         postscale_select_field <= cfg_new[`WDT_CFG_PS_LSB +: 4];
         prescale_select_bit    <= cfg_new[`WDT_CFG_PSA_BIT];
         window_disable_bit     <= cfg_new[`WDT_CFG_WIN_BIT];
         watchdog_enable_field  <= cfg_new[`WDT_CFG_EN_LSB +: 2];
      end
   end

   // Reset control register; flags survive device reset so software can
   // see why the device restarted
   always @(posedge aclk) begin
      if (!aresetn) begin
         software_watchdog_enable <= 1'b0;
         watchdog_timeout_flag    <= 1'b0;
         sleep_flag               <= 1'b0;
         idle_flag                <= 1'b0;
      end else begin
         if (device_reset) begin
            software_watchdog_enable <= 1'b0;
         end else if (do_write && sel_rstctl) begin
            software_watchdog_enable <= rstctl_new[`WDT_RC_SWEN_BIT];
         end
         if (reset_evt || wake_evt) begin
            watchdog_timeout_flag <= 1'b1;
         end else if (enter_ps) begin
            watchdog_timeout_flag <= 1'b0;
         end else if (do_write && sel_rstctl) begin
            watchdog_timeout_flag <= watchdog_timeout_flag &
                                     rstctl_new[`WDT_RC_TMO_BIT];
         end
         if (enter_ps && !power_save_idle) begin
            sleep_flag <= 1'b1;
         end else if (do_write && sel_rstctl) begin
            sleep_flag <= sleep_flag & rstctl_new[`WDT_RC_SLEEP_BIT];
         end
         if (enter_ps && power_save_idle) begin
            idle_flag <= 1'b1;
         end else if (do_write && sel_rstctl) begin
            idle_flag <= idle_flag & rstctl_new[`WDT_RC_IDLE_BIT];
         end
      end
   end

   // Interrupts: a new event wins over a clear in the same cycle
   assign irq_events = {wake_evt, early_clr, cnt_timeout};
   assign next_irq_status = (irq_status &
                             ~((do_write && sel_clr) ? wr_data[2:0] & {3{wr_strb[0]}}
                                                     : 3'h0)) | irq_events;

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= 3'h0;
         irq_enable <= 3'h0;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (do_write && sel_ena && wr_strb[0]) begin
            irq_enable <= wr_data[2:0];
         end
         irq <= |(next_irq_status & ((do_write && sel_ena && wr_strb[0]) ?
                                     wr_data[2:0] : irq_enable));
      end
   end

   // Core-facing outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         low_power_rc_osc_en <= 1'b0;
         watchdog_reset_req  <= 1'b0;
         wake_req            <= 1'b0;
      end else begin
         low_power_rc_osc_en <= run_en;
         watchdog_reset_req  <= reset_evt;
         wake_req            <= wake_evt;
      end
   end

   // Read decode
   always @* begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b1;
      if (araddr == `WDT_OFF_CONFIG) begin
         rd_word = cfg_word;
      end else if (araddr == `WDT_OFF_RSTCTL) begin
         rd_word = rstctl_word;
      end else if (araddr == `WDT_OFF_STATUS) begin
         rd_word = {22'h000000, mode, 5'h00, irq_status};
      end else if (araddr == `WDT_OFF_ENABLE) begin
         rd_word = {29'h00000000, irq_enable};
      end else if (araddr == `WDT_OFF_COUNT) begin
         rd_word = {10'h000, elapsed};
      end else if (araddr == `WDT_OFF_CLEAR) begin
         rd_word = 32'h00000000;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Read channel: one read under way, answered the cycle after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `WDT_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_word;
         rresp   <= rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule

`default_nettype wire

// ---- verif/wdt_monitor.sv ----
// Port checker of the watchdog block.
// Assumes binding onto wdt_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wdt_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        device_reset,
   input wire logic        clock_switch_done,
   input wire logic        power_save_instruction,
   input wire logic        low_power_rc_osc_en,
   input wire logic        watchdog_reset_req,
   input wire logic        wake_req
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_event_needs_osc: assert property ((watchdog_reset_req || wake_req) |->
      $past(low_power_rc_osc_en)) else $error("Watchdog event with oscillator off");
   a_reset_req_pulse: assert property (watchdog_reset_req |=> !watchdog_reset_req)
      else $error("Reset request longer than one cycle");
   a_wake_spacing: assert property (wake_req |=> !wake_req [*8])
      else $error("Wake request repeated too soon");
   a_devrst_restart: assert property (device_reset |=>
      (!watchdog_reset_req && !wake_req) [*8]) else $error("Event right after device reset");
   a_switch_restart: assert property (clock_switch_done |=>
      (!watchdog_reset_req && !wake_req) [*8]) else $error("Event right after clock switch");
   a_psave_restart: assert property (power_save_instruction |=> !wake_req [*8])
      else $error("Wake right after power save");
   a_write_refused: assert property (bvalid |-> !awready && !wready)
      else $error("Write taken while response pending");
   a_read_refused: assert property (rvalid |-> !arready)
      else $error("Read taken while data pending");
   a_bvalid_drop: assert property (bvalid && bready |=> !bvalid)
      else $error("Write response not released");
endmodule
bind wdt_top wdt_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .awready(awready),
   .wready(wready), .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid),
   .device_reset(device_reset), .clock_switch_done(clock_switch_done),
   .power_save_instruction(power_save_instruction), .low_power_rc_osc_en(low_power_rc_osc_en),
   .watchdog_reset_req(watchdog_reset_req), .wake_req(wake_req));
`default_nettype wire

// ---- verif/wdt_core_model.sv ----
// Processor core model: issues reset, switch, clear and power-save strobes.
// Assumes the bench calls op() from its main thread; strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model (
   input  wire logic aclk,
   input  wire logic wake_req,
   output var  logic device_reset,
   output var  logic clock_switch_done,
   output var  logic watchdog_clear_instruction,
   output var  logic power_save_instruction,
   output var  logic power_save_idle,
   output var  logic power_save_exit
);
   int wake_count;
   initial begin
      {device_reset, clock_switch_done, watchdog_clear_instruction} = 3'h0;
      {power_save_instruction, power_save_idle, power_save_exit} = 3'h0;
      wake_count = 0;
   end
   always @(posedge aclk) begin
      if (wake_req === 1'b1)
         wake_count <= wake_count + 1;
   end
   task automatic op(input int k, input logic idle);
      @(posedge aclk);
      power_save_idle <= idle;
      case (k)
         0: device_reset <= 1'b1;
         1: clock_switch_done <= 1'b1;
         2: watchdog_clear_instruction <= 1'b1;
         3: power_save_instruction <= 1'b1;
         default: power_save_exit <= 1'b1;
      endcase
      @(posedge aclk);
      {device_reset, clock_switch_done, watchdog_clear_instruction} <= 3'h0;
      {power_save_instruction, power_save_exit} <= 2'h0;
   endtask
endmodule
`default_nettype wire

// ---- verif/watchdog_timer_tb_top.sv ----
// Self-checking bench of the watchdog block.
// Assumes wdt_top, the core model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.vh"
module watchdog_timer_tb_top;
   localparam int D = 4;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         dev_rst, sw_done, clr, psave, psidle, psexit, osc_en, rst_req, wake;
   int          fail_count = 0, n_checks = 0, n, n_rst = 0, keep;
   logic [31:0] rd;
   logic [1:0]  rsp;
   logic [11:0] cfgs [4] = '{12'h340, 12'h341, 12'h350, 12'h342};
   int          ticks [4] = '{32, 64, 128, 128};
   always #25 aclk = ~aclk;
   wdt_top #(.ADDR_W(8), .OSC_DIV(D)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .device_reset(dev_rst), .clock_switch_done(sw_done),
      .watchdog_clear_instruction(clr), .power_save_instruction(psave),
      .power_save_idle(psidle), .power_save_exit(psexit), .low_power_rc_osc_en(osc_en),
      .watchdog_reset_req(rst_req), .wake_req(wake), .irq(irq));
   wdt_core_model u_core (.aclk(aclk), .wake_req(wake), .device_reset(dev_rst),
      .clock_switch_done(sw_done), .watchdog_clear_instruction(clr),
      .power_save_instruction(psave), .power_save_idle(psidle), .power_save_exit(psexit));
   always @(posedge aclk) begin
      if (rst_req === 1'b1)
         n_rst <= n_rst + 1;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      rsp = bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
   endtask
   // Counts cycles until the chosen event; bounded so a dead counter cannot hang
   task automatic wait_evt(input logic want_wake);
      n = 0;
      while (((want_wake ? wake : rst_req) !== 1'b1) && n < 3000) begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge aclk);
      fail_count++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(`WDT_OFF_CONFIG);
      chk("config", rd, 32'h5f);
      rdr(`WDT_OFF_RSTCTL);
      chk("rstctl", rd, 32'h0);
      rdr(8'h18);
      chk("unmapped", {rd[29:0], rsp}, {30'h0, `WDT_RESP_SLVERR});
      wr(8'h18, 32'h0);
      chk("wresp unmapped", rsp, `WDT_RESP_SLVERR);
      chk("osc off", osc_en, 1'b0);
      $display("test reset done");
      wr(`WDT_OFF_ENABLE, 32'h1);
      chk("wresp okay", rsp, `WDT_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         wr(`WDT_OFF_CONFIG, cfgs[i]);
         u_core.op(1, 1'b0);
         wait_evt(1'b0);
         chk("period", 32'(n >= ticks[i] * D - D && n <= ticks[i] * D + D + 4), 1);
      end
      chk("irq set", irq, 1'b1);
      rdr(`WDT_OFF_RSTCTL);
      chk("flag kept", rd[4], 1'b1);
      wr(`WDT_OFF_RSTCTL, 32'h0);
      rdr(`WDT_OFF_RSTCTL);
      chk("flag clear", rd[4], 1'b0);
      wr(`WDT_OFF_CLEAR, 32'h7);
      repeat (2) @(posedge aclk);
      chk("irq clear", irq, 1'b0);
      $display("test periods done");
      wr(`WDT_OFF_CONFIG, 32'h340);
      u_core.op(1, 1'b0);
      keep = n_rst;
      repeat (4) begin
         repeat (100) @(posedge aclk);
         u_core.op(2, 1'b0);
      end
      chk("no timeout", n_rst, keep);
      wr(`WDT_OFF_CONFIG, 32'h300);
      u_core.op(1, 1'b0);
      repeat (20) @(posedge aclk);
      u_core.op(2, 1'b0);
      wait_evt(1'b0);
      chk("early clear", 32'(n <= 3), 1);
      rdr(`WDT_OFF_STATUS);
      chk("early flag", rd[1], 1'b1);
      u_core.op(1, 1'b0);
      repeat (112) @(posedge aclk);
      u_core.op(2, 1'b0);
      keep = n_rst;
      repeat (60) @(posedge aclk);
      chk("late clear", n_rst, keep);
      $display("test clear done");
      wr(`WDT_OFF_CONFIG, 32'h240);
      repeat (2) @(posedge aclk);
      chk("soft off", osc_en, 1'b0);
      wr(`WDT_OFF_RSTCTL, 32'h20);
      repeat (2) @(posedge aclk);
      chk("soft on", osc_en, 1'b1);
      u_core.op(0, 1'b0);
      repeat (2) @(posedge aclk);
      chk("reset off", osc_en, 1'b0);
      rdr(`WDT_OFF_RSTCTL);
      chk("swen clear", rd[5], 1'b0);
      rdr(`WDT_OFF_COUNT);
      chk("count reset", rd, 32'h0);
      wr(`WDT_OFF_CONFIG, 32'h140);
      repeat (2) @(posedge aclk);
      chk("run on", osc_en, 1'b1);
      u_core.op(3, 1'b0);
      repeat (2) @(posedge aclk);
      chk("sleep off", osc_en, 1'b0);
      rdr(`WDT_OFF_RSTCTL);
      chk("sleep flag", rd[3], 1'b1);
      u_core.op(4, 1'b0);
      repeat (2) @(posedge aclk);
      chk("exit on", osc_en, 1'b1);
      $display("test enable done");
      wr(`WDT_OFF_RSTCTL, 32'h0);
      wr(`WDT_OFF_CONFIG, 32'h340);
      u_core.op(3, 1'b1);
      keep = n_rst;
      wait_evt(1'b1);
      chk("idle wake", 32'(n >= 32 * D - D && n <= 32 * D + D + 4), 1);
      chk("no reset", n_rst, keep);
      rdr(`WDT_OFF_RSTCTL);
      chk("wake flags", rd[4:2], 3'b101);
      rdr(`WDT_OFF_STATUS);
      chk("wake status", {rd[9:8], rd[2]}, 3'b001);
      wr(`WDT_OFF_RSTCTL, 32'h0);
      rdr(`WDT_OFF_RSTCTL);
      chk("sw clear", rd[4:2], 3'b000);
      chk("wakes", u_core.wake_count, 1);
      $display("test wake done");
      close_out();
   end
endmodule
`default_nettype wire
